// ---- lia_defs.svh ----
`ifndef LIA_DEFS_SVH
`define LIA_DEFS_SVH

// ---------------------------------------------------------------
// Register addresses and pages
// ---------------------------------------------------------------
`define LIA_ADDR_CTRL_MODE   8'hC9
`define LIA_ADDR_DATA_PORT   8'hD2
`define LIA_ADDR_POINTER     8'hD3
`define LIA_PAGE_CTRL_MODE   8'h0F
`define LIA_PAGE_INDIRECT    8'h00

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define LIA_RST_CTRL_MODE    8'h60
`define LIA_RST_POINTER      8'h00
`define LIA_RST_CORE         8'h00
`define LIA_RST_RDATA        8'h00

// ---------------------------------------------------------------
// Control mode fields
// ---------------------------------------------------------------
`define LIA_BIT_ENABLE       7
`define LIA_BIT_MASTER       6
`define LIA_BIT_AUTO_BAUD_SELECT        5
`define LIA_CTRL_USED_MSB    7
`define LIA_CTRL_USED_LSB    5
`define LIA_CTRL_UNUSED_MSB  4
`define LIA_UNUSED_ZERO      5'h00

// ---------------------------------------------------------------
// Indirect space
// ---------------------------------------------------------------
`define LIA_NUM_CORE_REGS    15
`define LIA_BUF_FIRST_IDX    8'h00
`define LIA_BUF_LAST_IDX     8'h07
`define LIA_ID_IDX           8'h0E
`define LIA_DENIED_RDATA     8'h00

`endif

// ---- lia_pkg.sv ----
package lia_pkg;

    typedef logic [7:0] lia_byte_t;

endpackage : lia_pkg

// ---- lia_core_regs.sv ----
`include "lia_defs.svh"

module lia_core_regs #(
    parameter int NUM_REGS = `LIA_NUM_CORE_REGS
) (
    input  wire logic                    clk_i,        // System clock
    input  wire logic                    rst_i,        // Sync reset
    input  wire logic                    host_we_i,    // Host write
    input  wire lia_pkg::lia_byte_t      host_idx_i,   // Host index
    input  wire lia_pkg::lia_byte_t      host_wdata_i, // Host data
    input  wire logic                    eng_we_i,     // Engine write
    input  wire lia_pkg::lia_byte_t      eng_idx_i,    // Engine index
    input  wire lia_pkg::lia_byte_t      eng_wdata_i,  // Engine data
    input  wire lia_pkg::lia_byte_t      rd_idx_i,     // Read index
    output lia_pkg::lia_byte_t           rd_data_o,    // Read data
    output logic [NUM_REGS*8-1:0]        regs_flat_o   // All registers
);
    import lia_pkg::*;

    if (NUM_REGS < 1 || NUM_REGS > 256)
    begin : g_chk
        $error("NUM_REGS must be 1 to 256");
    end

    lia_byte_t mem_reg  [NUM_REGS];
    lia_byte_t mem_next [NUM_REGS];

    // ---------------------------------------------------------------
    // Storage; engine wins a same-slot collision so status is not lost
    // ---------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < NUM_REGS; i++)
        begin
            mem_next[i] = mem_reg[i];
            if (eng_we_i && eng_idx_i == lia_byte_t'(i))
            begin
                mem_next[i] = eng_wdata_i;
            end
            else if (host_we_i && host_idx_i == lia_byte_t'(i))
            begin
                mem_next[i] = host_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < NUM_REGS; i++)
        begin
            if (rst_i)
            begin
                mem_reg[i] <= `LIA_RST_CORE;
            end
            else
            begin
                mem_reg[i] <= mem_next[i];
            end
        end
    end

    always_comb
    begin
        rd_data_o = `LIA_DENIED_RDATA;
        for (int i = 0; i < NUM_REGS; i++)
        begin
            if (rd_idx_i == lia_byte_t'(i))
            begin
                rd_data_o = mem_reg[i];
            end
            regs_flat_o[i*8 +: 8] = mem_reg[i];
        end
    end

endmodule : lia_core_regs

// ---- lia_indirect_access.sv ----
`include "lia_defs.svh"

module lia_indirect_access #(
    parameter int NUM_REGS = `LIA_NUM_CORE_REGS
) (
    input  wire logic                 clk_i,        // System clock
    input  wire logic                 rst_i,        // Sync reset
    input  wire lia_pkg::lia_byte_t   sfr_addr_i,   // SFR address
    input  wire lia_pkg::lia_byte_t   sfr_page_i,   // SFR page
    input  wire logic                 sfr_wr_i,     // Write strobe
    input  wire logic                 sfr_rd_i,     // Read strobe
    input  wire lia_pkg::lia_byte_t   sfr_wdata_i,  // Write data
    output lia_pkg::lia_byte_t        sfr_rdata_o,  // Read data
    output logic                      sfr_rvalid_o, // Read data valid
    input  wire logic                 data_request_pending_i, // Id seen
    input  wire logic                 bus_active_i, // Frame on bus
    input  wire logic                 eng_we_i,     // Engine write
    input  wire lia_pkg::lia_byte_t   eng_idx_i,    // Engine index
    input  wire lia_pkg::lia_byte_t   eng_wdata_i,  // Engine data
    output logic [NUM_REGS*8-1:0]     core_regs_o,  // Core contents
    output logic                      core_wr_o,    // Host wrote core
    output lia_pkg::lia_byte_t        core_wr_idx_o, // Written index
    output logic                      controller_enable_o, // Enable
    output logic                      master_mode_o, // Master role
    output logic                      auto_baud_select_o // Autobaud
);
    import lia_pkg::*;

    if (NUM_REGS < 1 || NUM_REGS > 256)
    begin : g_chk
        $error("NUM_REGS must be 1 to 256");
    end

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    logic      sel_ptr;
    logic      sel_data;
    logic      sel_ctrl;
    logic      ptr_in_range;
    logic      gated_idx;
    logic      access_ok;
    logic      data_wr_ok;
    lia_byte_t core_rd_data;

    lia_byte_t ptr_reg;
    lia_byte_t ptr_next;
    logic [2:0] ctrl_reg;
    logic [2:0] ctrl_next;
    lia_byte_t rdata_reg;
    lia_byte_t rdata_next;
    logic      rvalid_reg;
    logic      rvalid_next;

    // Named copy so the reset value can be part-selected
    localparam lia_byte_t CTRL_RST = `LIA_RST_CTRL_MODE;

    assign sel_ptr  = sfr_addr_i == `LIA_ADDR_POINTER &&
                      sfr_page_i == `LIA_PAGE_INDIRECT;
    assign sel_data = sfr_addr_i == `LIA_ADDR_DATA_PORT &&
                      sfr_page_i == `LIA_PAGE_INDIRECT;
    assign sel_ctrl = sfr_addr_i == `LIA_ADDR_CTRL_MODE &&
                      sfr_page_i == `LIA_PAGE_CTRL_MODE;

    // Pointer beyond the last core register reaches nothing
    // Nine bits so a full 256-entry space still compares correctly
    assign ptr_in_range = {1'b0, ptr_reg} < 9'(NUM_REGS);

    assign gated_idx = (ptr_reg >= `LIA_BUF_FIRST_IDX &&
                        ptr_reg <= `LIA_BUF_LAST_IDX) ||
                       ptr_reg == `LIA_ID_IDX;

    // Slave firmware must not race the frame engine on shared bytes
    assign access_ok = master_mode_o || !gated_idx ||
                       (data_request_pending_i && !bus_active_i);

    assign data_wr_ok = sfr_wr_i && sel_data && ptr_in_range &&
                        access_ok;

    assign core_wr_o     = data_wr_ok;
    assign core_wr_idx_o = ptr_reg;

    // ---------------------------------------------------------------
    // Core register file
    // ---------------------------------------------------------------
    lia_core_regs #(
        .NUM_REGS (NUM_REGS)
    ) u_core_regs (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .host_we_i    (data_wr_ok),
        .host_idx_i   (ptr_reg),
        .host_wdata_i (sfr_wdata_i),
        .eng_we_i     (eng_we_i),
        .eng_idx_i    (eng_idx_i),
        .eng_wdata_i  (eng_wdata_i),
        .rd_idx_i     (ptr_reg),
        .rd_data_o    (core_rd_data),
        .regs_flat_o  (core_regs_o)
    );

    // ---------------------------------------------------------------
    // Direct registers
    // ---------------------------------------------------------------
    always_comb
    begin
        ptr_next  = ptr_reg;
        ctrl_next = ctrl_reg;
        // Only a direct write moves the pointer
        if (sfr_wr_i && sel_ptr)
        begin
            ptr_next = sfr_wdata_i;
        end
        // Low bits are simply not stored
        if (sfr_wr_i && sel_ctrl)
        begin
            ctrl_next = sfr_wdata_i[`LIA_CTRL_USED_MSB:
                                    `LIA_CTRL_USED_LSB];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ptr_reg  <= `LIA_RST_POINTER;
            ctrl_reg <= CTRL_RST[`LIA_CTRL_USED_MSB:`LIA_CTRL_USED_LSB];
        end
        else
        begin
            ptr_reg  <= ptr_next;
            ctrl_reg <= ctrl_next;
        end
    end

    // ---------------------------------------------------------------
    // Read path, one cycle after the strobe
    // ---------------------------------------------------------------
    always_comb
    begin
        rdata_next  = rdata_reg;
        rvalid_next = sfr_rd_i;
        if (sfr_rd_i)
        begin
            rdata_next = `LIA_DENIED_RDATA;
            if (sel_ptr)
            begin
                rdata_next = ptr_reg;
            end
            else if (sel_ctrl)
            begin
                rdata_next = {ctrl_reg, `LIA_UNUSED_ZERO};
            end
            else if (sel_data && ptr_in_range && access_ok)
            begin
                rdata_next = core_rd_data;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_reg  <= `LIA_RST_RDATA;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign sfr_rdata_o  = rdata_reg;
    assign sfr_rvalid_o = rvalid_reg;

    // ---------------------------------------------------------------
    // Controller steering
    // ---------------------------------------------------------------
    localparam int EN_POS = `LIA_BIT_ENABLE - `LIA_CTRL_USED_LSB;
    localparam int MS_POS = `LIA_BIT_MASTER - `LIA_CTRL_USED_LSB;
    localparam int AB_POS = `LIA_BIT_AUTO_BAUD_SELECT - `LIA_CTRL_USED_LSB;

    assign controller_enable_o = ctrl_reg[EN_POS];
    assign master_mode_o       = ctrl_reg[MS_POS];
    // Autobaud is forced off in master role; stored bit still reads back
    assign auto_baud_select_o  = ctrl_reg[AB_POS] &&
                                 !ctrl_reg[MS_POS];

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_ptr_write: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sfr_wr_i && sel_ptr |=> ptr_reg == $past(sfr_wdata_i))
        else $error("pointer write not stored");

    a_data_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sfr_rd_i && sel_data && ptr_in_range && access_ok
        |=> sfr_rvalid_o && sfr_rdata_o == $past(core_rd_data))
        else $error("data port read wrong");

    a_data_write: assert property (
        @(posedge clk_i) disable iff (rst_i)
        data_wr_ok && !(eng_we_i && eng_idx_i == ptr_reg)
        |=> core_rd_data == $past(sfr_wdata_i))
        else $error("data port write not stored");

    a_range_write: assert property (
        @(posedge clk_i) disable iff (rst_i)
        {1'b0, ptr_reg} >= 9'(NUM_REGS) |-> !core_wr_o)
        else $error("write beyond core registers");

    a_enable_bit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sfr_wr_i && sel_ctrl
        |=> controller_enable_o == $past(sfr_wdata_i[`LIA_BIT_ENABLE]))
        else $error("enable bit wrong");

    a_mode_bit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sfr_wr_i && sel_ctrl
        |=> master_mode_o == $past(sfr_wdata_i[`LIA_BIT_MASTER]))
        else $error("mode bit wrong");

    a_auto_baud_select_master: assert property (
        @(posedge clk_i) disable iff (rst_i)
        master_mode_o |-> !auto_baud_select_o)
        else $error("autobaud active in master role");

    a_auto_baud_select_slave: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sfr_wr_i && sel_ctrl && !sfr_wdata_i[`LIA_BIT_MASTER]
        |=> auto_baud_select_o == $past(sfr_wdata_i[`LIA_BIT_AUTO_BAUD_SELECT]))
        else $error("slave baud select wrong");

    a_ctrl_low_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sfr_rd_i && sel_ctrl
        |=> sfr_rdata_o[`LIA_CTRL_UNUSED_MSB:0] == `LIA_UNUSED_ZERO)
        else $error("unused control bits not zero");

    a_slave_gate: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !master_mode_o && gated_idx &&
        (!data_request_pending_i || bus_active_i) |-> !core_wr_o)
        else $error("slave buffer write while locked");

    a_ptr_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (sfr_rd_i || sfr_wr_i) && sel_data && !(sfr_wr_i && sel_ptr)
        |=> $stable(ptr_reg))
        else $error("pointer moved on data access");

    a_rvalid_one: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !sfr_rd_i |=> !sfr_rvalid_o)
        else $error("read valid stood too long");

    a_ptr_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sfr_rd_i && sel_ptr |=> sfr_rdata_o == $past(ptr_reg))
        else $error("pointer read wrong");

    a_range_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sfr_rd_i && sel_data && !ptr_in_range
        |=> sfr_rdata_o == `LIA_DENIED_RDATA)
        else $error("read beyond core registers not zero");

    a_slave_read_lock: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sfr_rd_i && sel_data && !master_mode_o && gated_idx &&
        (!data_request_pending_i || bus_active_i)
        |=> sfr_rdata_o == `LIA_DENIED_RDATA)
        else $error("slave buffer read while locked");

    a_ctrl_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sfr_rd_i && sel_ctrl
        |=> sfr_rdata_o[`LIA_BIT_ENABLE] == $past(controller_enable_o) &&
            sfr_rdata_o[`LIA_BIT_MASTER] == $past(master_mode_o))
        else $error("control read back wrong");

    a_ptr_steady: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(sfr_wr_i && sel_ptr) |=> $stable(ptr_reg))
        else $error("pointer moved without a write");

endmodule : lia_indirect_access

// ---- lia_engine_model.sv ----
module lia_engine_model (
    input  wire logic                clk_i,      // System clock
    input  wire logic                rst_i,      // Sync reset
    input  wire logic                pend_cmd_i, // Bench: identifier seen
    input  wire logic                act_cmd_i,  // Bench: frame running
    input  wire logic                we_cmd_i,   // Bench: engine write
    input  wire lia_pkg::lia_byte_t  idx_cmd_i,  // Bench: write index
    input  wire lia_pkg::lia_byte_t  dat_cmd_i,  // Bench: write byte
    output logic                     pend_o,     // Request pending
    output logic                     act_o,      // Bus active
    output logic                     we_o,       // Engine write
    output lia_pkg::lia_byte_t       idx_o,      // Engine index
    output lia_pkg::lia_byte_t       dat_o       // Engine data
);
    timeunit 1ns;
    timeprecision 1ps;
    import lia_pkg::*;

    // ------------------------------------------------------------
    // Frame engine status and write port
    // ------------------------------------------------------------
    // Data toggles while idle so a stale byte can never look valid
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pend_o <= 1'b0;
            act_o  <= 1'b0;
            we_o   <= 1'b0;
            idx_o  <= 8'h00;
            dat_o  <= 8'h00;
        end
        else
        begin
            pend_o <= pend_cmd_i;
            act_o  <= act_cmd_i;
            we_o   <= we_cmd_i;
            idx_o  <= we_cmd_i ? idx_cmd_i : ~idx_o;
            dat_o  <= we_cmd_i ? dat_cmd_i : ~dat_o;
        end
    end
endmodule : lia_engine_model

// ---- lin_indirect_register_access_bench.sv ----
`include "lia_defs.svh"

module lin_indirect_register_access_bench import lia_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic            clk, rst, wr, rd, we_c, pend_c, act_c, wr_seen;
    lia_byte_t       addr, page, wdata, idx_c, dat_c, rdata, eidx, edat;
    logic            rvalid, pend, act, ewe, cwr, en, mst, abd;
    lia_byte_t       cwidx, k;
    logic [119:0]    core;
    int              fail_count, comparisons;

    lia_indirect_access #(.NUM_REGS(15)) u_dut (
        .clk_i(clk), .rst_i(rst), .sfr_addr_i(addr), .sfr_page_i(page),
        .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata),
        .sfr_rdata_o(rdata), .sfr_rvalid_o(rvalid),
        .data_request_pending_i(pend), .bus_active_i(act),
        .eng_we_i(ewe), .eng_idx_i(eidx), .eng_wdata_i(edat),
        .core_regs_o(core), .core_wr_o(cwr), .core_wr_idx_o(cwidx),
        .controller_enable_o(en), .master_mode_o(mst),
        .auto_baud_select_o(abd));

    lia_engine_model u_eng (
        .clk_i(clk), .rst_i(rst), .pend_cmd_i(pend_c), .act_cmd_i(act_c),
        .we_cmd_i(we_c), .idx_cmd_i(idx_c), .dat_cmd_i(dat_c),
        .pend_o(pend), .act_o(act), .we_o(ewe), .idx_o(eidx),
        .dat_o(edat));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check_byte(input string n, input lia_byte_t e,
                              input lia_byte_t g);
        comparisons++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : check_byte

    task automatic report_and_stop;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    task automatic sfr_write(input lia_byte_t pg, ad, d);
        @(posedge clk);
        page  <= pg;
        addr  <= ad;
        wdata <= d;
        wr    <= 1'b1;
        #1 wr_seen = cwr;
        @(posedge clk);
        wr <= 1'b0;
    endtask : sfr_write

    task automatic sfr_read(input lia_byte_t pg, ad, e, input string n);
        @(posedge clk);
        page <= pg;
        addr <= ad;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check_byte(n, e, rdata);
        check_byte("read valid", 8'h01, {7'h00, rvalid});
    endtask : sfr_read

    task automatic ind_wr(input lia_byte_t ad, d);
        sfr_write(`LIA_PAGE_INDIRECT, ad, d);
    endtask : ind_wr

    task automatic rd_dat(input lia_byte_t e);
        sfr_read(`LIA_PAGE_INDIRECT, `LIA_ADDR_DATA_PORT, e, "data port");
    endtask : rd_dat

    task automatic rd_ptr(input lia_byte_t e);
        sfr_read(`LIA_PAGE_INDIRECT, `LIA_ADDR_POINTER, e, "pointer");
    endtask : rd_ptr

    task automatic ctrl_wr(input lia_byte_t d, e_rd, e_mode);
        sfr_write(`LIA_PAGE_CTRL_MODE, `LIA_ADDR_CTRL_MODE, d);
        sfr_read(`LIA_PAGE_CTRL_MODE, `LIA_ADDR_CTRL_MODE, e_rd, "control");
        check_byte("mode outputs", e_mode, {5'h00, en, mst, abd});
    endtask : ctrl_wr

    task automatic chk_core(input lia_byte_t ix, e);
        #1 check_byte("core byte", e, core[ix*8 +: 8]);
    endtask : chk_core

    task automatic set_bus(input logic p, a);
        @(posedge clk);
        pend_c <= p;
        act_c  <= a;
        repeat (2) @(posedge clk);
    endtask : set_bus

    // ------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        repeat (3000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end

    initial
    begin
        {rst, wr, rd, we_c, pend_c, act_c, wr_seen} = 7'h41;
        {addr, page, wdata, idx_c, dat_c} = 40'h00;
        {fail_count, comparisons} = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1 check_byte("mode outputs", 8'h02,
                      {5'h00, en, mst, abd});
        sfr_read(`LIA_PAGE_CTRL_MODE, `LIA_ADDR_CTRL_MODE, 8'h60,
                 "ctl");
        rd_ptr(8'h00);
        rd_dat(8'h00);
        ind_wr(`LIA_ADDR_POINTER, 8'hFF);
        rd_ptr(8'hFF);
        ind_wr(`LIA_ADDR_DATA_PORT, 8'h77);
        rd_dat(8'h00);
        for (k = 8'h00; k < 8'h0F; k++)
        begin
            ind_wr(`LIA_ADDR_POINTER, k);
            ind_wr(`LIA_ADDR_DATA_PORT, 8'h30 + k);
            check_byte("write index", k, cwidx);
            chk_core(k, 8'h30 + k);
        end
        for (k = 8'h00; k < 8'h0F; k++)
        begin
            ind_wr(`LIA_ADDR_POINTER, k);
            rd_dat(8'h30 + k);
            rd_dat(8'h30 + k);
            rd_ptr(k);
        end
        ind_wr(`LIA_ADDR_POINTER, 8'h0F);
        ind_wr(`LIA_ADDR_DATA_PORT, 8'h99);
        rd_dat(8'h00);
        chk_core(8'h0E, 8'h3E);
        ctrl_wr(8'hFF, 8'hE0, 8'h06);
        ctrl_wr(8'hA0, 8'hA0, 8'h05);
        ctrl_wr(8'h60, 8'h60, 8'h02);
        ctrl_wr(8'h80, 8'h80, 8'h04);
        ind_wr(`LIA_ADDR_POINTER, 8'h0E);
        ind_wr(`LIA_ADDR_DATA_PORT, 8'h55);
        check_byte("host write seen", 8'h00, {7'h00, wr_seen});
        chk_core(8'h0E, 8'h3E);
        rd_dat(8'h00);
        ind_wr(`LIA_ADDR_POINTER, 8'h08);
        ind_wr(`LIA_ADDR_DATA_PORT, 8'h5A);
        chk_core(8'h08, 8'h5A);
        set_bus(1'b1, 1'b1);
        ind_wr(`LIA_ADDR_POINTER, 8'h07);
        ind_wr(`LIA_ADDR_DATA_PORT, 8'h66);
        chk_core(8'h07, 8'h37);
        rd_dat(8'h00);
        set_bus(1'b1, 1'b0);
        ind_wr(`LIA_ADDR_DATA_PORT, 8'h66);
        check_byte("host write seen", 8'h01, {7'h00, wr_seen});
        rd_dat(8'h66);
        @(posedge clk);
        we_c  <= 1'b1;
        idx_c <= 8'h03;
        dat_c <= 8'hC3;
        @(posedge clk);
        we_c <= 1'b0;
        @(posedge clk);
        chk_core(8'h03, 8'hC3);
        ind_wr(`LIA_ADDR_POINTER, 8'h03);
        rd_dat(8'hC3);
        ind_wr(8'hD4, 8'h12);
        sfr_read(`LIA_PAGE_INDIRECT, 8'hD4, 8'h00, "unmapped");
        sfr_read(`LIA_PAGE_INDIRECT, `LIA_ADDR_CTRL_MODE, 8'h00, "page");
        ctrl_wr(8'h1F, 8'h00, 8'h00);
        // Mid-run reset must bring every register back
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 check_byte("mode outputs", 8'h02,
                      {5'h00, en, mst, abd});
        rd_ptr(8'h00);
        chk_core(8'h08, 8'h00);
        report_and_stop();
    end
endmodule : lin_indirect_register_access_bench
